// File: tns_defines.svh
`ifndef TNS_DEFINES_SVH
`define TNS_DEFINES_SVH

// clock rates and the derived prescale counts
`define TNS_SYS_HZ        20000000
`define TNS_DEV_HZ        2000000
`define TNS_DEV_DIV       (`TNS_SYS_HZ / `TNS_DEV_HZ)
`define TNS_TONE_PRE      16
`define TNS_NOISE_DIV0    512
`define TNS_NOISE_DIV1    1024
`define TNS_NOISE_DIV2    2048

// control byte field positions
`define TNS_MARK_BIT      7
`define TNS_SEL_HI        6
`define TNS_SEL_LO        4
`define TNS_LOW_HI        3
`define TNS_HIGH_HI       5
`define TNS_FB_BIT        2
`define TNS_RATE_HI       1

// register select codes
`define TNS_R_T1_DIV      3'h0
`define TNS_R_T1_VOL      3'h1
`define TNS_R_T2_DIV      3'h2
`define TNS_R_T2_VOL      3'h3
`define TNS_R_T3_DIV      3'h4
`define TNS_R_T3_VOL      3'h5
`define TNS_R_NZ_SET      3'h6
`define TNS_R_NZ_VOL      3'h7

// reset values
`define TNS_VOL_OFF       4'hF
`define TNS_DIV_RST       10'h000
`define TNS_NZ_RST        3'h0
`define TNS_LFSR_SEED     15'h4000

`endif

// File: tns_pkg.sv
`include "tns_defines.svh"

package tns_pkg;
  // register select codes as a type
  typedef enum logic [2:0] {
    TNS_T1_DIV = `TNS_R_T1_DIV,
    TNS_T1_VOL = `TNS_R_T1_VOL,
    TNS_T2_DIV = `TNS_R_T2_DIV,
    TNS_T2_VOL = `TNS_R_T2_VOL,
    TNS_T3_DIV = `TNS_R_T3_DIV,
    TNS_T3_VOL = `TNS_R_T3_VOL,
    TNS_NZ_SET = `TNS_R_NZ_SET,
    TNS_NZ_VOL = `TNS_R_NZ_VOL
  } tns_reg_e;

  // noise shift rate select
  typedef enum logic [1:0] {
    TNS_RATE_512  = 2'h0,
    TNS_RATE_1024 = 2'h1,
    TNS_RATE_2048 = 2'h2,
    TNS_RATE_TONE = 2'h3
  } tns_rate_e;

  typedef logic [11:0] tns_amp_t;
endpackage

// File: tns_tone.sv
`timescale 1ns/10ps
`default_nettype none

// one square wave channel: half period is divider prescaled ticks
module tns_tone
  import tns_pkg::*;
#(
  parameter int DIV_W = 10
)(
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic             tick,
  input  wire logic [DIV_W-1:0] divider,
  output logic                  wave
);

  logic [DIV_W-1:0] cnt_q;   // ticks since last toggle
  logic [DIV_W-1:0] cnt_d;
  logic             wave_q;  // square wave level
  logic             wave_d;
  logic [DIV_W-1:0] cnt_inc; // next count, wraps

  // divider zero wraps the full counter, giving the longest period
  always_comb
  begin
    cnt_d   = cnt_q;
    wave_d  = wave_q;
    cnt_inc = cnt_q + 1'b1;
    if (tick)
    begin
      // a lowered divider ends the running half period at the next tick
      // rather than wrapping through all 1024 counts first
      if ((divider == '0) ? (cnt_inc == '0) : (cnt_inc >= divider))
      begin
        cnt_d  = '0;
        wave_d = ~wave_q;
      end
      else
      begin
        cnt_d = cnt_inc;
      end
    end
  end

  // state registers
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_q  <= '0;
      wave_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      wave_q <= wave_d;
    end
  end

  assign wave = wave_q;

endmodule

`default_nettype wire

// File: tns_sound.sv
`timescale 1ns/10ps
`default_nettype none

`include "tns_defines.svh"

// Operation
// - three tones, one noise, attenuated, summed
// - three bit code picks one of eight
// - msb one selects, msb zero continues a divider
// - tone frequency is clock over 32N
// - divider load alone stays silent
// - volume byte carries four bit code
// - two dB steps, code fifteen silent
// - noise from a shift register
// - noise byte: feedback bit, two rate bits
// - feedback one white, zero periodic
// - rate 512, 1024, 2048 or tone3
module tns_sound
  import tns_pkg::*;
#(
  parameter int DIV_W  = 10,
  parameter int LFSR_W = 15
)(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  ctrl_byte,
  input  wire logic        ctrl_write,
  output logic [13:0]      audio_out
);

  localparam logic [3:0]  DEV_LAST  = 4'(`TNS_DEV_DIV - 1);
  localparam logic [3:0]  PRE_LAST  = 4'(`TNS_TONE_PRE - 1);
  localparam logic [10:0] NZ_LAST0  = 11'(`TNS_NOISE_DIV0 - 1);
  localparam logic [10:0] NZ_LAST1  = 11'(`TNS_NOISE_DIV1 - 1);
  localparam logic [10:0] NZ_LAST2  = 11'(`TNS_NOISE_DIV2 - 1);

  // register file
  logic [DIV_W-1:0] div_q [3];   // tone dividers
  logic [DIV_W-1:0] div_d [3];
  logic [3:0]       vol_q [4];   // volume codes, index 3 is noise
  logic [3:0]       vol_d [4];
  logic [2:0]       nz_q;        // feedback bit and rate select
  logic [2:0]       nz_d;
  tns_reg_e         sel_q;       // last latched select
  tns_reg_e         sel_d;
  logic             nz_load;     // noise setup written this cycle

  // rate generation
  logic [3:0]       dev_cnt_q;   // system to device clock divider
  logic [3:0]       dev_cnt_d;
  logic [3:0]       pre_cnt_q;   // device clock to tone tick
  logic [3:0]       pre_cnt_d;
  logic             dev_tick;    // device clock enable
  logic             tone_tick;   // tone counter enable

  // noise state
  logic [10:0]      nz_cnt_q;    // fixed rate divider
  logic [10:0]      nz_cnt_d;
  logic [LFSR_W-1:0] lfsr_q;     // noise shift register
  logic [LFSR_W-1:0] lfsr_d;
  logic             t3_prev_q;   // tone3 level one cycle back
  logic             t3_prev_d;
  logic             nz_shift;    // shift enable
  logic [10:0]      nz_last;     // selected divider end count

  // output mix
  logic [13:0]      mix_q;
  logic [13:0]      mix_d;
  logic [2:0]       waves;       // tone square waves

  // attenuation: amplitude per code, 2 dB apart, last entry silent
  function automatic tns_amp_t vol_amp(input logic [3:0] code);
    tns_amp_t a;
    a = 12'h000;
    case (code)
      4'h0:    a = 12'hFFF;
      4'h1:    a = 12'hCB5;
      4'h2:    a = 12'hA18;
      4'h3:    a = 12'h805;
      4'h4:    a = 12'h65F;
      4'h5:    a = 12'h50F;
      4'h6:    a = 12'h405;
      4'h7:    a = 12'h331;
      4'h8:    a = 12'h289;
      4'h9:    a = 12'h204;
      4'hA:    a = 12'h19A;
      4'hB:    a = 12'h145;
      4'hC:    a = 12'h102;
      4'hD:    a = 12'h0CD;
      4'hE:    a = 12'h0A3;
      default: a = 12'h000;
    endcase
    return a;
  endfunction

  // control byte decode and register writes
  always_comb
  begin
    div_d   = div_q;
    vol_d   = vol_q;
    nz_d    = nz_q;
    sel_d   = sel_q;
    nz_load = 1'b0;
    if (ctrl_write)
    begin
      if (ctrl_byte[`TNS_MARK_BIT]) // first or only byte
      begin
        sel_d = tns_reg_e'(ctrl_byte[`TNS_SEL_HI:`TNS_SEL_LO]);
        case (tns_reg_e'(ctrl_byte[`TNS_SEL_HI:`TNS_SEL_LO]))
          TNS_T1_DIV, TNS_T2_DIV, TNS_T3_DIV:
          begin
            // low nibble only; volume untouched
            div_d[ctrl_byte[`TNS_SEL_HI:`TNS_SEL_HI-1]][3:0] = ctrl_byte[`TNS_LOW_HI:0];
          end
          TNS_T1_VOL, TNS_T2_VOL, TNS_T3_VOL, TNS_NZ_VOL:
          begin
            vol_d[ctrl_byte[`TNS_SEL_HI:`TNS_SEL_HI-1]] = ctrl_byte[`TNS_LOW_HI:0];
          end
          TNS_NZ_SET:
          begin
            nz_d    = ctrl_byte[`TNS_FB_BIT:0];
            nz_load = 1'b1;
          end
          default:
          begin
            sel_d = sel_q;
          end
        endcase
      end
      else if (!sel_q[0] && sel_q != TNS_NZ_SET) // continuation
      begin
        // high six bits of the latched divider
        div_d[sel_q[2:1]][DIV_W-1:4] = ctrl_byte[`TNS_HIGH_HI:0];
      end
    end
  end

  // register file storage
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < 3; i++)
      begin
        div_q[i] <= `TNS_DIV_RST;
      end
      for (int i = 0; i < 4; i++)
      begin
        vol_q[i] <= `TNS_VOL_OFF;
      end
      nz_q  <= `TNS_NZ_RST;
      sel_q <= TNS_T1_DIV;
    end
    else
    begin
      div_q <= div_d;
      vol_q <= vol_d;
      nz_q  <= nz_d;
      sel_q <= sel_d;
    end
  end

  // prescalers: 20 MHz to 2 MHz, then to the tone tick
  always_comb
  begin
    dev_tick  = (dev_cnt_q == DEV_LAST);
    dev_cnt_d = dev_tick ? 4'h0 : dev_cnt_q + 4'h1;
    pre_cnt_d = pre_cnt_q;
    if (dev_tick)
    begin
      pre_cnt_d = pre_cnt_q + 4'h1;
    end
    tone_tick = dev_tick && (pre_cnt_q == PRE_LAST);
  end

  // prescaler registers
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dev_cnt_q <= 4'h0;
      pre_cnt_q <= 4'h0;
    end
    else
    begin
      dev_cnt_q <= dev_cnt_d;
      pre_cnt_q <= pre_cnt_d;
    end
  end

  // three tone channels
  for (genvar g = 0; g < 3; g++)
  begin : g_tone
    tns_tone #(
      .DIV_W   (DIV_W)
    ) u_tone (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .tick    (tone_tick),
      .divider (div_q[g]),
      .wave    (waves[g])
    );
  end

  // noise clock select and shift register
  always_comb
  begin
    case (tns_rate_e'(nz_q[`TNS_RATE_HI:0]))
      TNS_RATE_512:  nz_last = NZ_LAST0;
      TNS_RATE_1024: nz_last = NZ_LAST1;
      default:       nz_last = NZ_LAST2;
    endcase
    nz_cnt_d  = nz_cnt_q;
    nz_shift  = 1'b0;
    t3_prev_d = waves[2];
    if (tns_rate_e'(nz_q[`TNS_RATE_HI:0]) == TNS_RATE_TONE)
    begin
      nz_shift = waves[2] && !t3_prev_q; // tone3 rising edge
    end
    else if (dev_tick)
    begin
      nz_shift = (nz_cnt_q >= nz_last);
      nz_cnt_d = nz_shift ? 11'h000 : nz_cnt_q + 11'h001;
    end
    lfsr_d = lfsr_q;
    if (nz_load)
    begin
      // restart so a mode change begins from a known pattern
      lfsr_d   = LFSR_W'(`TNS_LFSR_SEED);
      nz_cnt_d = 11'h000;
    end
    else if (nz_shift)
    begin
      // white uses xor feedback, periodic only recirculates
      lfsr_d = {nz_q[`TNS_FB_BIT] ? (lfsr_q[0] ^ lfsr_q[1]) : lfsr_q[0],
                lfsr_q[LFSR_W-1:1]};
    end
  end

  // noise registers
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      nz_cnt_q  <= 11'h000;
      lfsr_q    <= LFSR_W'(`TNS_LFSR_SEED);
      t3_prev_q <= 1'b0;
    end
    else
    begin
      nz_cnt_q  <= nz_cnt_d;
      lfsr_q    <= lfsr_d;
      t3_prev_q <= t3_prev_d;
    end
  end

  // attenuate each source and sum; unsigned, so silence is zero
  always_comb
  begin
    mix_d = 14'h0000;
    for (int i = 0; i < 3; i++)
    begin
      if (waves[i])
      begin
        mix_d = mix_d + {2'b00, vol_amp(vol_q[i])};
      end
    end
    if (lfsr_q[0])
    begin
      mix_d = mix_d + {2'b00, vol_amp(vol_q[3])};
    end
  end

  // output register
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mix_q <= 14'h0000;
    end
    else
    begin
      mix_q <= mix_d;
    end
  end

  assign audio_out = mix_q;

endmodule

`default_nettype wire

// File: tns_sound_chk.sv
`timescale 1ns/10ps
`default_nettype none
// shadows the register file from the byte stream, times output edges
module tns_sound_chk
  import tns_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic [7:0]  ctrl_byte,
  input wire logic        ctrl_write,
  input wire logic [13:0] audio_out
);
  localparam logic [11:0] AMP [16] = '{12'hFFF, 12'hCB5, 12'hA18, 12'h805, 12'h65F, 12'h50F,
    12'h405, 12'h331, 12'h289, 12'h204, 12'h19A, 12'h145, 12'h102, 12'h0CD, 12'h0A3, 12'h000};
  logic [3:0]  vol_q [4], vol_d [4]; // index is select over two
  logic [9:0]  div_q [3], div_d [3];
  logic [2:0]  sel_q, sel_d, nz_q, nz_d;
  logic [13:0] prev_q, prev_d;
  logic [23:0] cnt_q, cnt_d;         // cycles since the output last moved
  logic        seen_q, seen_d, arm_q, arm_d;
  logic        chg, solo_t, solo_n;
  logic [15:0] vv;
  int          per_t, per_n;
  assign vv = {vol_q[3], vol_q[2], vol_q[1], vol_q[0]};
  assign solo_t = vol_q[0] != 4'hF && vv[15:4] == 12'hFFF;
  assign solo_n = vol_q[3] != 4'hF && vv[11:0] == 12'hFFF;
  assign per_t = 160 * ((div_q[0] == 10'h000) ? 1024 : int'(div_q[0]));
  assign per_n = (nz_q[1:0] == 2'h3) ? 2 * 160 * ((div_q[2] == 10'h000) ? 1024 : int'(div_q[2]))
               : 5120 << nz_q[1:0];
  // every sum of attenuated sources that may legally appear
  function automatic bit legal(logic [13:0] a, logic [15:0] v);
    logic [13:0] s;
    legal = 1'b0;
    for (int m = 0; m < 16; m++)
    begin
      s = 14'h0000;
      for (int k = 0; k < 4; k++)
        if (m[k])
          s = s + 14'(AMP[v[4*k+:4]]);
      legal = legal | (s == a);
    end
  endfunction
  // arming waits two edges after any write, so write side effects are skipped
  always_comb
  begin
    vol_d  = vol_q;
    div_d  = div_q;
    sel_d  = sel_q;
    nz_d   = nz_q;
    chg    = audio_out != prev_q;
    prev_d = audio_out;
    cnt_d  = chg ? 24'h000000 : cnt_q + 24'h000001;
    seen_d = ctrl_write ? 1'b0 : (seen_q | chg);
    arm_d  = ctrl_write ? 1'b0 : (chg ? seen_q : arm_q);
    if (ctrl_write && ctrl_byte[7])
    begin
      sel_d = ctrl_byte[6:4];
      if (ctrl_byte[4])
        vol_d[ctrl_byte[6:5]] = ctrl_byte[3:0];
      else if (ctrl_byte[6:5] == 2'h3)
        nz_d = ctrl_byte[2:0];
      else
        div_d[ctrl_byte[6:5]][3:0] = ctrl_byte[3:0];
    end
    else if (ctrl_write && !sel_q[0] && sel_q != 3'h6)
      div_d[sel_q[2:1]][9:4] = ctrl_byte[5:0];
  end
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      vol_q  <= '{default: 4'hF};
      div_q  <= '{default: 10'h000};
      sel_q  <= 3'h0;
      nz_q   <= 3'h0;
      prev_q <= 14'h0000;
      cnt_q  <= 24'h000000;
      seen_q <= 1'b0;
      arm_q  <= 1'b0;
    end
    else
    begin
      vol_q  <= vol_d;
      div_q  <= div_d;
      sel_q  <= sel_d;
      nz_q   <= nz_d;
      prev_q <= prev_d;
      cnt_q  <= cnt_d;
      seen_q <= seen_d;
      arm_q  <= arm_d;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  reset_quiet_a: assert property ($rose(resetn) |-> audio_out == 14'h0000)
    else $error("output not silent after reset");
  off_silent_a: assert property ($past(vv) == 16'hFFFF |-> audio_out == 14'h0000)
    else $error("output moves with all sources off");
  mix_legal_a: assert property (legal(audio_out, $past(vv)))
    else $error("output is no sum of attenuated sources");
  sum_range_a: assert property (audio_out <= 14'h3FFC)
    else $error("output above four full sources");
  tone_period_a: assert property (chg && arm_q && solo_t |-> cnt_q == per_t - 1)
    else $error("tone half period wrong");
  tone_late_a: assert property (arm_q && solo_t |-> cnt_q < per_t)
    else $error("tone edge missing");
  noise_rate_a: assert property (chg && arm_q && solo_n |-> (cnt_q + 1) % per_n == 0)
    else $error("noise edge off the shift grid");
  noise_periodic_a: assert property (chg && arm_q && solo_n && !nz_q[2] |->
    cnt_q + 1 == ((prev_q != 14'h0000) ? 1 : 14) * per_n) else $error("periodic noise wrong");
  noise_gap_a: assert property (arm_q && solo_n |-> cnt_q < 15 * per_n)
    else $error("noise stuck");
  cover property (chg && arm_q && solo_t);
  cover property (chg && arm_q && solo_n && nz_q[2]);
  cover property (chg && arm_q && solo_n && !nz_q[2]);
  cover property (ctrl_write && !ctrl_byte[7]);
endmodule
`default_nettype wire

// File: tns_host.sv
`timescale 1ns/10ps
`default_nettype none
// host side: one byte per strobe cycle, junk on the bus while idle
module tns_host (
  input  wire logic       sys_clk,
  output var  logic [7:0] ctrl_byte,
  output var  logic       ctrl_write
);
  initial
  begin
    ctrl_byte  = 8'h00;
    ctrl_write = 1'b0;
  end
  // more keeps the strobe up for a back to back byte
  task automatic put(input logic [7:0] b, input bit more);
    @(posedge sys_clk);
    ctrl_byte  <= b;
    ctrl_write <= 1'b1;
    if (!more)
    begin
      @(posedge sys_clk);
      ctrl_write <= 1'b0;
      ctrl_byte  <= ~b;
    end
  endtask
  // divider as a pair, low nibble first
  task automatic put_div(input logic [2:0] sel, input logic [9:0] n);
    put({1'b1, sel, n[3:0]}, 1'b1);
    put({2'b00, n[9:4]}, 1'b0);
  endtask
endmodule
`default_nettype wire

// File: tns_sound_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "tns_defines.svh"
// drives the sound block through the host model, checks levels and timing
module tns_sound_tb_top;
  localparam logic [11:0] AMP [16] = '{12'hFFF, 12'hCB5, 12'hA18, 12'h805, 12'h65F, 12'h50F,
    12'h405, 12'h331, 12'h289, 12'h204, 12'h19A, 12'h145, 12'h102, 12'h0CD, 12'h0A3, 12'h000};
  logic        sys_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic [7:0]  ctrl_byte;
  logic        ctrl_write;
  logic [13:0] audio_out, mx;
  logic [9:0]  div;
  logic [3:0]  v;
  int          n_mismatch  = 0;
  int          comparisons = 0;
  int          n;
  always #25 sys_clk = ~sys_clk;
  tns_sound i_tns_sound (.sys_clk(sys_clk), .resetn(resetn), .ctrl_byte(ctrl_byte),
    .ctrl_write(ctrl_write), .audio_out(audio_out));
  tns_host i_tns_host (.sys_clk(sys_clk), .ctrl_byte(ctrl_byte), .ctrl_write(ctrl_write));
  task automatic check(input string what, input logic [13:0] got, input logic [13:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // cycles until the output moves; a hang counts as a mismatch
  task automatic wait_chg(output int cyc);
    logic [13:0] a;
    a   = audio_out;
    cyc = 0;
    do
    begin
      @(negedge sys_clk); // settled, away from the launching edge
      cyc++;
    end while (audio_out === a && cyc < 100000);
    if (cyc >= 100000)
      n_mismatch++;
  endtask
  // highest output level over a span of cycles
  task automatic peak(input int span);
    mx = 14'h0000;
    repeat (span)
    begin
      @(negedge sys_clk);
      mx = (audio_out > mx) ? audio_out : mx;
    end
  endtask
  // length in shifts of run k of the noise bit after a reseed
  function automatic int noise_run(input bit fb, input int k);
    logic [14:0] s;
    int          len;
    int          r;
    s         = 15'(`TNS_LFSR_SEED);
    len       = 0;
    r         = 0;
    noise_run = 0;
    for (int i = 0; i < 64; i++)
    begin
      len++;
      if (s[0] != s[1]) // this shift flips the noise bit
      begin
        if (r == k)
          noise_run = len;
        r++;
        len = 0;
      end
      s = {fb ? (s[0] ^ s[1]) : s[0], s[14:1]};
    end
  endfunction
  task automatic silence;
    for (int c = 0; c < 4; c++)
      i_tns_host.put({1'b1, 2'(c), 5'h1F}, 1'b0);
  endtask
  initial
  begin
    void'($urandom(60));
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    @(negedge sys_clk);
    check("reset level", audio_out, 14'h0000);
    i_tns_host.put_div(3'h0, 10'h001);
    peak(400);
    check("divider only", mx, 14'h0000);
    // all sixteen codes; skip the cycles that still show the last code
    for (int c = 0; c < 16; c++)
    begin
      i_tns_host.put({4'h9, 4'(c)}, 1'b0);
      repeat (3) @(posedge sys_clk);
      peak(340);
      check("volume level", mx, {2'b00, AMP[c]});
    end
    // each tone alone; a marker-0 byte after a volume byte must be dropped
    for (int ch = 0; ch < 3; ch++)
    begin
      div = 10'($urandom_range(1, 4) + 16 * ch);
      v   = 4'($urandom_range(0, 14));
      silence();
      i_tns_host.put_div(3'(2 * ch), div);
      i_tns_host.put({1'b1, 3'(2 * ch + 1), v}, 1'b1);
      i_tns_host.put(8'h3F, 1'b0);
      wait_chg(n);
      wait_chg(n);
      wait_chg(n);
      check("tone half period", 14'(n), 14'(160 * div));
    end
    // noise shifted by tone3, periodic then white; reseed before unmuting
    // tone3 at divider one gives a rising edge every 320 cycles
    silence();
    i_tns_host.put_div(3'h4, 10'h001);
    for (int fb = 0; fb < 2; fb++)
    begin
      i_tns_host.put({5'b11100, 1'(fb), 2'b11}, 1'b0);
      i_tns_host.put(8'hF0, 1'b0);
      wait_chg(n);
      wait_chg(n);
      check("noise high span", 14'(n), 14'(320 * noise_run(1'(fb), 1)));
      wait_chg(n);
      check("noise low span", 14'(n), 14'(320 * noise_run(1'(fb), 2)));
      i_tns_host.put(8'hFF, 1'b0);
    end
    // a tone playing, then a reset in mid-run must silence everything
    i_tns_host.put(8'h90, 1'b0);
    peak(1300);
    check("tone before reset", mx, {2'b00, AMP[0]});
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    peak(400);
    check("silent after reset", mx, 14'h0000);
    print_verdict();
  end
  initial
  begin
    #(50 * 100000);
    n_mismatch++;
    print_verdict();
  end
endmodule
bind tns_sound tns_sound_chk i_tns_sound_chk (.sys_clk(sys_clk), .resetn(resetn),
  .ctrl_byte(ctrl_byte), .ctrl_write(ctrl_write), .audio_out(audio_out));
`default_nettype wire
